// ==== lwp_pkg.sv ====
package lwp_pkg;

  localparam logic [31:0] ADDR_CMD_PORT = 32'h0000_0000;
  localparam logic [31:0] ADDR_PIX_PORT = 32'h0000_0004;
  localparam logic [31:0] ADDR_STATUS = 32'h0000_0008;
  localparam logic [31:0] ADDR_PIX_COUNT = 32'h0000_000C;

  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_LAST_DC_BIT = 1;

  localparam int PANEL_H = 240;
  localparam int PANEL_V = 320;
  localparam logic [16:0] PIXEL_MAX = 17'(PANEL_H * PANEL_V);

  localparam int RED_MSB = 15;
  localparam int RED_LSB = 11;
  localparam int GRN_MSB = 10;
  localparam int GRN_LSB = 5;
  localparam int BLU_MSB = 4;
  localparam int BLU_LSB = 0;

  localparam int CLK_PERIOD_NS = 50;
  localparam int SETUP_NS = 50;
  localparam int STROBE_LOW_NS = 50;
  localparam int HOLD_NS = 50;
  localparam logic [3:0] SETUP_CYC = 4'((SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] STROBE_CYC =
    4'((STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] HOLD_CYC = 4'((HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic dc;
    logic [15:0] word;
  } lwp_req_t;

  typedef struct packed {
    logic select_n;
    logic data_command_sel;
    logic write_strobe_n;
    logic read_strobe_n;
    logic [15:0] data;
  } lwp_pins_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SETUP = 2'b01,
    ST_STROBE = 2'b10,
    ST_HOLD = 2'b11
  } lwp_state_t;

endpackage

// ==== lwp_bus_seq.sv ====
`timescale 1ns/1ps
module lwp_bus_seq (
  input wire logic clk,
  input wire logic rst,
  input wire lwp_pkg::lwp_req_t req,
  input wire logic req_valid,
  output logic busy,
  output lwp_pkg::lwp_pins_t pins
);
  lwp_pkg::lwp_state_t state_ff, nxt_state;
  logic [3:0] cnt_ff, nxt_cnt;
  lwp_pkg::lwp_pins_t pins_ff, nxt_pins;

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_pins = pins_ff;
    nxt_pins.read_strobe_n = 1'b1;
    case (state_ff)
      lwp_pkg::ST_IDLE: begin
        if (req_valid) begin
          nxt_pins.select_n = 1'b0;
          nxt_pins.data_command_sel = req.dc;
          nxt_pins.data = req.word;
          nxt_cnt = lwp_pkg::SETUP_CYC;
          nxt_state = lwp_pkg::ST_SETUP;
        end
      end
      lwp_pkg::ST_SETUP: begin
        nxt_cnt = cnt_ff - 4'h1;
        if (cnt_ff == 4'h1) begin
          nxt_pins.write_strobe_n = 1'b0;
          nxt_cnt = lwp_pkg::STROBE_CYC;
          nxt_state = lwp_pkg::ST_STROBE;
        end
      end
      lwp_pkg::ST_STROBE: begin
        nxt_cnt = cnt_ff - 4'h1;
        if (cnt_ff == 4'h1) begin
          // data and select stay put past the rising edge
          nxt_pins.write_strobe_n = 1'b1;
          nxt_cnt = lwp_pkg::HOLD_CYC;
          nxt_state = lwp_pkg::ST_HOLD;
        end
      end
      lwp_pkg::ST_HOLD: begin
        nxt_cnt = cnt_ff - 4'h1;
        if (cnt_ff == 4'h1) begin
          nxt_pins.select_n = 1'b1;
          nxt_state = lwp_pkg::ST_IDLE;
        end
      end
      default: nxt_state = lwp_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= lwp_pkg::ST_IDLE;
      cnt_ff <= 4'h0;
      pins_ff <= '{select_n: 1'b1, data_command_sel: 1'b1, write_strobe_n: 1'b1,
                   read_strobe_n: 1'b1, data: 16'h0000};
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      pins_ff <= nxt_pins;
    end
  end

  assign busy = (state_ff != lwp_pkg::ST_IDLE);
  assign pins = pins_ff;
endmodule

// ==== lwp_axil_slave.sv ====
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
module lwp_axil_slave (
  input wire logic clk,
  input wire logic rst,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [31:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire logic seq_busy,
  input wire logic [31:0] status_word,
  input wire logic [31:0] count_word,
  output logic req_valid,
  output lwp_pkg::lwp_req_t req
);
  logic aw_ff, nxt_aw, w_ff, nxt_w, b_ff, nxt_b, r_ff, nxt_r, go_ff, nxt_go;
  logic [31:0] awa_ff, nxt_awa, wd_ff, nxt_wd, rd_ff, nxt_rd;
  logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
  lwp_pkg::lwp_req_t req_ff, nxt_req;
  logic hit_cmd, hit_pix;
  logic awrdy_ff, nxt_awrdy, wrdy_ff, nxt_wrdy, arrdy_ff, nxt_arrdy;

  always_comb begin
    nxt_aw = aw_ff;
    nxt_w = w_ff;
    nxt_awa = awa_ff;
    nxt_wd = wd_ff;
    nxt_b = b_ff;
    nxt_bresp = bresp_ff;
    nxt_r = r_ff;
    nxt_rd = rd_ff;
    nxt_rresp = rresp_ff;
    nxt_go = 1'b0;
    nxt_req = req_ff;
    hit_cmd = (awa_ff[31:2] == lwp_pkg::ADDR_CMD_PORT[31:2]);
    hit_pix = (awa_ff[31:2] == lwp_pkg::ADDR_PIX_PORT[31:2]);
    if (awvalid && awready) begin
      nxt_aw = 1'b1;
      nxt_awa = awaddr;
    end
    if (wvalid && wready) begin
      nxt_w = 1'b1;
      nxt_wd = wdata;
    end
    // hold the response while the lcd bus is busy, stalling the host
    if (aw_ff && w_ff && !b_ff && !seq_busy && !go_ff) begin
      nxt_aw = 1'b0;
      nxt_w = 1'b0;
      nxt_b = 1'b1;
      nxt_bresp = (hit_cmd || hit_pix) ? lwp_pkg::RESP_OKAY : lwp_pkg::RESP_SLVERR;
      nxt_go = hit_cmd || hit_pix;
      nxt_req.dc = hit_pix;
      nxt_req.word = wd_ff[15:0];
    end
    if (b_ff && bready) begin
      nxt_b = 1'b0;
    end
    if (arvalid && arready) begin
      nxt_r = 1'b1;
      nxt_rresp = lwp_pkg::RESP_OKAY;
      case (araddr[31:2])
        lwp_pkg::ADDR_STATUS[31:2]: nxt_rd = status_word;
        lwp_pkg::ADDR_PIX_COUNT[31:2]: nxt_rd = count_word;
        default: begin
          nxt_rd = 32'h0000_0000;
          nxt_rresp = lwp_pkg::RESP_SLVERR;
        end
      endcase
    end else if (r_ff && rready) begin
      nxt_r = 1'b0;
    end
    // readies registered so the host sees them straight from flops
    nxt_awrdy = !nxt_aw && !nxt_b;
    nxt_wrdy = !nxt_w && !nxt_b;
    nxt_arrdy = !nxt_r;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      aw_ff <= 1'b0;
      w_ff <= 1'b0;
      awa_ff <= 32'h0000_0000;
      wd_ff <= 32'h0000_0000;
      b_ff <= 1'b0;
      bresp_ff <= 2'h0;
      r_ff <= 1'b0;
      rd_ff <= 32'h0000_0000;
      rresp_ff <= 2'h0;
      go_ff <= 1'b0;
      req_ff <= '0;
      awrdy_ff <= 1'b1;
      wrdy_ff <= 1'b1;
      arrdy_ff <= 1'b1;
    end else begin
      aw_ff <= nxt_aw;
      w_ff <= nxt_w;
      awa_ff <= nxt_awa;
      wd_ff <= nxt_wd;
      b_ff <= nxt_b;
      bresp_ff <= nxt_bresp;
      r_ff <= nxt_r;
      rd_ff <= nxt_rd;
      rresp_ff <= nxt_rresp;
      go_ff <= nxt_go;
      req_ff <= nxt_req;
      awrdy_ff <= nxt_awrdy;
      wrdy_ff <= nxt_wrdy;
      arrdy_ff <= nxt_arrdy;
    end
  end

  assign awready = awrdy_ff;
  assign wready = wrdy_ff;
  assign bvalid = b_ff;
  assign bresp = bresp_ff;
  assign arready = arrdy_ff;
  assign rvalid = r_ff;
  assign rdata = rd_ff;
  assign rresp = rresp_ff;
  assign req_valid = go_ff;
  assign req = req_ff;
endmodule

// ==== lwp_top.sv ====
// Summary of operation
// - select line low marks a command word, high marks a data word
// - driver latches data at write strobe rising edge; keep lines steady across it
// - command codes travel on the low eight data lines only; here all sixteen bits of the written word are driven
// - each data word carries one pixel across all sixteen lines
// - pixel packs red 15..11, green 10..5, blue 4..0
// - the link is a sixteen bit 8080 style write bus
// - panel is 240 by 320; pixel count tracked against that bound
// - a write to offset zero becomes one command word
// - a write to offset four becomes one data word
`timescale 1ns/1ps
module lwp_top (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_AWADDR,
  input wire logic [2:0] S_AXI_AWPROT,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  output logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_ARADDR,
  input wire logic [2:0] S_AXI_ARPROT,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic LCD_SELECT_N,
  output logic DATA_COMMAND_SEL,
  output logic LCD_WRITE_STROBE_N,
  output logic LCD_READ_STROBE_N,
  output logic [15:0] LCD_DATA
);
  logic seq_busy, req_valid;
  lwp_pkg::lwp_req_t req;
  lwp_pkg::lwp_pins_t pins;
  logic [16:0] pix_cnt_ff, nxt_pix_cnt;
  logic last_dc_ff, nxt_last_dc;
  logic [31:0] status_word, count_word;

  // command resets the pixel run; data words count up, saturating at panel size
  always_comb begin
    nxt_pix_cnt = pix_cnt_ff;
    nxt_last_dc = last_dc_ff;
    if (req_valid) begin
      nxt_last_dc = req.dc;
      if (!req.dc) begin
        nxt_pix_cnt = 17'h0_0000;
      end else if (pix_cnt_ff != lwp_pkg::PIXEL_MAX) begin
        nxt_pix_cnt = pix_cnt_ff + 17'h0_0001;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      pix_cnt_ff <= 17'h0_0000;
      last_dc_ff <= 1'b1;
    end else begin
      pix_cnt_ff <= nxt_pix_cnt;
      last_dc_ff <= nxt_last_dc;
    end
  end

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[lwp_pkg::STAT_BUSY_BIT] = seq_busy || req_valid;
    status_word[lwp_pkg::STAT_LAST_DC_BIT] = last_dc_ff;
    count_word = {15'h0000, pix_cnt_ff};
  end

  lwp_axil_slave u_slave (
    .clk(CLK),
    .rst(SYS_RST),
    .awvalid(S_AXI_AWVALID),
    .awready(S_AXI_AWREADY),
    .awaddr(S_AXI_AWADDR),
    .wvalid(S_AXI_WVALID),
    .wready(S_AXI_WREADY),
    .wdata(S_AXI_WDATA),
    .wstrb(S_AXI_WSTRB),
    .bvalid(S_AXI_BVALID),
    .bready(S_AXI_BREADY),
    .bresp(S_AXI_BRESP),
    .arvalid(S_AXI_ARVALID),
    .arready(S_AXI_ARREADY),
    .araddr(S_AXI_ARADDR),
    .rvalid(S_AXI_RVALID),
    .rready(S_AXI_RREADY),
    .rdata(S_AXI_RDATA),
    .rresp(S_AXI_RRESP),
    .seq_busy(seq_busy),
    .status_word(status_word),
    .count_word(count_word),
    .req_valid(req_valid),
    .req(req)
  );

  // word passes unchanged: low byte is the command, all 16 bits a 5-6-5 pixel
  lwp_bus_seq u_seq (
    .clk(CLK),
    .rst(SYS_RST),
    .req(req),
    .req_valid(req_valid),
    .busy(seq_busy),
    .pins(pins)
  );

  assign LCD_SELECT_N = pins.select_n;
  assign DATA_COMMAND_SEL = pins.data_command_sel;
  assign LCD_WRITE_STROBE_N = pins.write_strobe_n;
  assign LCD_READ_STROBE_N = pins.read_strobe_n;
  assign LCD_DATA = pins.data;
endmodule

// ==== lwp_checker.sv ====
`timescale 1ns/1ps
module lwp_checker (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_AWADDR,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic S_AXI_BVALID,
  input wire logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic S_AXI_RVALID,
  input wire logic LCD_SELECT_N,
  input wire logic DATA_COMMAND_SEL,
  input wire logic LCD_WRITE_STROBE_N,
  input wire logic LCD_READ_STROBE_N,
  input wire logic [15:0] LCD_DATA
);
  logic [31:0] aw_ff;
  logic [31:0] nxt_aw;
  logic [15:0] wd_ff;
  logic [15:0] nxt_wd;
  // last accepted write; a new one waits for its response, so it names the next cycle
  always_comb begin
    nxt_aw = (S_AXI_AWVALID && S_AXI_AWREADY) ? S_AXI_AWADDR : aw_ff;
    nxt_wd = (S_AXI_WVALID && S_AXI_WREADY) ? S_AXI_WDATA[15:0] : wd_ff;
  end
  always_ff @(posedge CLK) begin
    aw_ff <= SYS_RST ? 32'h0 : nxt_aw;
    wd_ff <= SYS_RST ? 16'h0 : nxt_wd;
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  AST_RD_HIGH: assert property (LCD_READ_STROBE_N)
    else $error("read strobe low");
  AST_SETUP: assert property ($fell(LCD_SELECT_N) |=> $fell(LCD_WRITE_STROBE_N))
    else $error("strobe not one cycle after select");
  AST_STROBE: assert property ($fell(LCD_WRITE_STROBE_N) |=>
    $rose(LCD_WRITE_STROBE_N) ##1 $rose(LCD_SELECT_N))
    else $error("strobe or release wrong");
  AST_STEADY: assert property (!LCD_SELECT_N && !$past(LCD_SELECT_N) |->
    $stable(LCD_DATA) && $stable(DATA_COMMAND_SEL))
    else $error("bus moved during cycle");
  AST_DC: assert property ($fell(LCD_SELECT_N) |->
    DATA_COMMAND_SEL == (aw_ff == lwp_pkg::ADDR_PIX_PORT))
    else $error("select line wrong for offset");
  AST_WORD: assert property ($fell(LCD_SELECT_N) |-> LCD_DATA[7:0] == wd_ff[7:0] &&
    (!DATA_COMMAND_SEL || LCD_DATA == wd_ff))
    else $error("bus word differs from write");
  AST_B_CYC: assert property ($rose(S_AXI_BVALID) && S_AXI_BRESP == lwp_pkg::RESP_OKAY
    |-> ##[1:4] $fell(LCD_SELECT_N))
    else $error("accepted write gave no cycle");
  AST_STALL: assert property ($rose(S_AXI_BVALID) |-> LCD_SELECT_N)
    else $error("response during bus cycle");
  AST_RVALID: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read answer late");
endmodule
bind lwp_top lwp_checker chk (.CLK(CLK), .SYS_RST(SYS_RST),
  .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_AWADDR(S_AXI_AWADDR),
  .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_WDATA(S_AXI_WDATA),
  .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_ARVALID(S_AXI_ARVALID),
  .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RVALID(S_AXI_RVALID), .LCD_SELECT_N(LCD_SELECT_N),
  .DATA_COMMAND_SEL(DATA_COMMAND_SEL), .LCD_WRITE_STROBE_N(LCD_WRITE_STROBE_N),
  .LCD_READ_STROBE_N(LCD_READ_STROBE_N), .LCD_DATA(LCD_DATA));

// ==== lwp_lcd_model.sv ====
`timescale 1ns/1ps
module lwp_lcd_model (
  input wire logic select_n,
  input wire logic dc,
  input wire logic wr_n,
  input wire logic rd_n,
  input wire logic [15:0] data
);
  logic [16:0] words[$];
  int reads = 0;
  // the block never reads the panel, so any read strobe is a fault
  always @(negedge rd_n) begin
    reads++;
  end
  // a deselected driver ignores strobes
  always @(posedge wr_n) begin
    if (!select_n && rd_n) begin
      words.push_back({dc, data});
    end
  end
endmodule

// ==== testbench.sv ====
`timescale 1ns/1ps
module testbench;
  logic CLK, SYS_RST, awv, wv, bready, arv, rready, awrdy, wrdy, bvalid, arrdy, rvalid;
  logic sel_n, dc, wr_n, rd_n;
  logic [31:0] awaddr, wdata, araddr, rdata, d;
  logic [1:0] bresp, rresp, r;
  logic [15:0] lcd_d;
  logic [15:0] pix[4] = '{16'hF800, 16'h07E0, 16'h001F, 16'hAD4A};
  int failures, checked, cycles;
  lwp_top uut (.CLK(CLK), .SYS_RST(SYS_RST), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awrdy),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWPROT(3'h0), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_BRESP(bresp), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arrdy), .S_AXI_ARADDR(araddr),
    .S_AXI_ARPROT(3'h0), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .LCD_SELECT_N(sel_n), .DATA_COMMAND_SEL(dc),
    .LCD_WRITE_STROBE_N(wr_n), .LCD_READ_STROBE_N(rd_n), .LCD_DATA(lcd_d));
  lwp_lcd_model mdl (.select_n(sel_n), .dc(dc), .wr_n(wr_n), .rd_n(rd_n), .data(lcd_d));
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // valids drop as each channel is taken; bready stays up until the answer
  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    // an edge first, so a back-to-back call never drives bready twice in one step
    @(posedge CLK);
    awaddr <= a;
    wdata <= v;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge CLK);
      if (awv && awrdy) awv <= 1'b0;
      if (wv && wrdy) wv <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a);
    @(posedge CLK);
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge CLK);
      if (arv && arrdy) arv <= 1'b0;
    end while (!rvalid);
    r = rresp;
    d = rdata;
    rready <= 1'b0;
  endtask
  task automatic t_cmd();
    logic [16:0] w;
    wr(lwp_pkg::ADDR_CMD_PORT, 32'hFFFF_A52C);
    chk("cmd resp", 32'(r), 32'(lwp_pkg::RESP_OKAY));
    repeat (6) @(posedge CLK);
    chk("cmd words", mdl.words.size(), 1);
    w = mdl.words.pop_front();
    chk("cmd dc", 32'(w[16]), 0);
    chk("cmd code", 32'(w[7:0]), 32'h2C);
    rd(lwp_pkg::ADDR_PIX_COUNT);
    chk("count cleared", d, 0);
    rd(lwp_pkg::ADDR_STATUS);
    chk("last dc cmd", 32'(d[lwp_pkg::STAT_LAST_DC_BIT]), 0);
    $display("command test done");
  endtask
  task automatic t_pix();
    for (int i = 0; i < 4; i++) begin
      wr(lwp_pkg::ADDR_PIX_PORT, {16'hFFFF, pix[i]});
    end
    rd(lwp_pkg::ADDR_STATUS);
    chk("busy", 32'(d[lwp_pkg::STAT_BUSY_BIT]), 1);
    chk("last dc pix", 32'(d[lwp_pkg::STAT_LAST_DC_BIT]), 1);
    repeat (6) @(posedge CLK);
    chk("pix words", mdl.words.size(), 4);
    for (int i = 0; i < 4; i++) begin
      chk("pix word", 32'(mdl.words.pop_front()), {15'h0, 1'b1, pix[i]});
    end
    rd(lwp_pkg::ADDR_PIX_COUNT);
    chk("count", d, 4);
    $display("pixel test done");
  endtask
  task automatic t_err();
    wr(32'h0000_0010, 32'h0000_1234);
    chk("bad wr resp", 32'(r), 32'(lwp_pkg::RESP_SLVERR));
    repeat (6) @(posedge CLK);
    chk("bad wr words", mdl.words.size(), 0);
    for (int i = 0; i < 2; i++) begin
      rd(32'(i * 4));
      chk("wo read resp", 32'(r), 32'(lwp_pkg::RESP_SLVERR));
      chk("wo read data", d, 0);
    end
    rd(lwp_pkg::ADDR_STATUS);
    chk("idle", 32'(d[lwp_pkg::STAT_BUSY_BIT]), 0);
    chk("read strobes", mdl.reads, 0);
    $display("error test done");
  endtask
  initial begin
    CLK = 1'b0;
    forever #25 CLK = ~CLK;
  end
  always @(posedge CLK) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      failures++;
      final_report();
    end
  end
  initial begin
    {SYS_RST, awv, wv, bready, arv, rready} = 6'h20;
    {awaddr, wdata, araddr} = '0;
    {failures, checked, cycles} = '0;
    repeat (5) @(posedge CLK);
    SYS_RST <= 1'b0;
    chk("idle pins", {29'h0, sel_n, wr_n, rd_n}, 32'h7);
    t_cmd();
    t_pix();
    t_err();
    t_cmd();
    final_report();
  end
endmodule
